// ### src/hsc_pkg.sv
// Package with register map, reset values, codes and carrier types of the homing sequencer.
package hsc_pkg;

    // Parameter addresses on the parameter port.
    localparam logic [15:0] HSC_ADDR_SP_LIMIT    = 16'h280c;
    localparam logic [15:0] HSC_ADDR_SW_OFFSET   = 16'h280e;
    localparam logic [15:0] HSC_ADDR_HOME_POS    = 16'h2816;
    localparam logic [15:0] HSC_ADDR_OT_LIMIT    = 16'h281a;
    localparam logic [15:0] HSC_ADDR_METHOD      = 16'h2802;
    localparam logic [15:0] HSC_ADDR_MODE_ACTION = 16'h2000;
    localparam logic [15:0] HSC_ADDR_STATUS      = 16'h2002;

    // Reset values.
    localparam logic [31:0] HSC_RST_SP_LIMIT  = 32'h0000_0000;
    localparam logic [31:0] HSC_RST_SW_OFFSET = 32'h0000_00c8;
    localparam logic [31:0] HSC_RST_HOME_POS  = 32'h0000_0000;
    localparam logic [31:0] HSC_RST_OT_LIMIT  = 32'h0000_0000;
    localparam logic [15:0] HSC_RST_METHOD    = 16'h0000;
    localparam logic [7:0]  HSC_RST_ACTION    = 8'h00;
    localparam logic [15:0] HSC_RST_STATUS    = 16'h4000;

    // Method code range and action codes.
    localparam logic [15:0] HSC_METHOD_MAX = 16'h0023;
    localparam logic [7:0]  HSC_ACT_REF    = 8'h12;
    localparam logic [7:0]  HSC_ACT_SET    = 8'h02;

    // Status word bit positions.
    localparam int HSC_STAT_END = 14;
    localparam int HSC_STAT_ERR = 15;

    // Parameter port request.
    typedef struct packed {
        logic [15:0] addr;
        logic [31:0] wdata;
        logic        wr;
        logic        rd;
    } hsc_par_req_t;

    // Switch and index pins.
    typedef struct packed {
        logic negative_end_switch;
        logic positive_end_switch;
        logic ref_switch;
        logic index_pulse;
    } hsc_switch_t;

    // Command to the motion profile.
    typedef struct packed {
        logic run;
        logic dir_neg;
        logic slow;
    } hsc_motion_t;

    // Decoded method.
    typedef struct packed {
        logic valid;
        logic pos_set;
        logic index_only;
        logic use_limit;
        logic seek_neg;
        logic invert;
        logic outside;
        logic end_index;
    } hsc_plan_t;

    // Turns a method code into the movement plan; unknown codes come back invalid.
    function automatic hsc_plan_t hsc_decode(input logic [15:0] m);
        hsc_plan_t  p;
        logic [1:0] v;
        p = '0;
        v = 2'b00;
        if (m == 16'h0001 || m == 16'h0002 || m == 16'h0011 || m == 16'h0012) begin
            p.valid     = 1'b1;
            p.use_limit = 1'b1;
            p.seek_neg  = (m == 16'h0001 || m == 16'h0011);
            p.invert    = 1'b1;
            p.outside   = 1'b1;
            p.end_index = (m < 16'h0011);
        end else if (m >= 16'h0007 && m <= 16'h000e) begin
            p.valid     = 1'b1;
            p.end_index = 1'b1;
            p.seek_neg  = (m >= 16'h000b);
            v = p.seek_neg ? 2'(m - 16'h000b) : 2'(m - 16'h0007);
        end else if (m >= 16'h0017 && m <= 16'h001e) begin
            p.valid    = 1'b1;
            p.seek_neg = (m >= 16'h001b);
            v = p.seek_neg ? 2'(m - 16'h001b) : 2'(m - 16'h0017);
        end else if (m == 16'h001f || m == 16'h0022) begin
            p.valid      = 1'b1;
            p.index_only = 1'b1;
            p.end_index  = 1'b1;
            p.seek_neg   = (m == 16'h001f);
        end else if (m == 16'h0023) begin
            p.valid   = 1'b1;
            p.pos_set = 1'b1;
        end
        if (!p.use_limit && !p.index_only && !p.pos_set && p.valid) begin
            p.invert  = (v < 2'd2);
            p.outside = (v == 2'd0 || v == 2'd3);
        end
        return p;
    endfunction

    // Unsigned distance between two signed positions.
    function automatic logic [31:0] hsc_dist(input logic [31:0] a, input logic [31:0] b);
        logic [31:0] d;
        d = a - b;
        return d[31] ? 32'(-d) : d;
    endfunction

endpackage

// ### src/hsc_homing_sequence_control.sv
// Homing sequencer: method decode, reference movement, monitors and status.
`timescale 1ns/1ns

module hsc_homing_sequence_control
    import hsc_pkg::*;
(
    input  wire logic         clk,
    input  wire logic         rst,
    input  wire logic         ce,
    input  wire hsc_par_req_t par_req,
    output logic [31:0]       par_rdata,
    input  wire hsc_switch_t  switch_pins,
    input  wire logic [31:0]  act_pos,
    input  wire logic         standstill,
    input  wire logic         halt_req,
    input  wire logic         quick_stop_req,
    input  wire logic         fault_req,
    output hsc_motion_t       motion,
    output logic              pos_load,
    output logic [31:0]       pos_load_value,
    output logic              zero_valid,
    output logic [15:0]       drive_status_word
);

    typedef enum logic [2:0] {
        HSC_IDLE, HSC_SEEK, HSC_LEAVE, HSC_FINAL, HSC_BRAKE
    } hsc_state_t;

    hsc_state_t  state_reg;
    hsc_switch_t sw_meta_reg;
    hsc_switch_t sw_sync_reg;
    logic        idx_prev_reg;
    logic [31:0] sp_limit_reg, sw_offset_reg, home_pos_reg, ot_limit_reg;
    logic [15:0] method_reg;
    logic [7:0]  action_reg;
    logic [31:0] sp_limit_act_reg, sw_offset_act_reg, home_pos_act_reg, ot_limit_act_reg;
    hsc_plan_t   plan_reg;
    logic        reversed_reg;
    logic        seek_dir_reg;
    logic [31:0] mark_reg;
    logic        good_reg, err_reg;
    logic        start_ref, start_set, wr_hit;
    logic        sw_active, end_ahead, idx_rise;
    logic        out_dir, fin_dir;
    hsc_plan_t   plan_now;

    // Pins are asynchronous to clk, so every one passes two flip-flops first.
    always_ff @(posedge clk) begin
        if (rst) begin
            sw_meta_reg  <= '0;
            sw_sync_reg  <= '0;
            idx_prev_reg <= 1'b0;
        end else if (ce) begin
            sw_meta_reg  <= switch_pins;
            sw_sync_reg  <= sw_meta_reg;
            idx_prev_reg <= sw_sync_reg.index_pulse;
        end
    end

    // Start decode; a start is refused while a movement is under way.
    always_comb begin
        plan_now  = hsc_decode(method_reg);
        wr_hit    = par_req.wr && par_req.addr == HSC_ADDR_MODE_ACTION && state_reg == HSC_IDLE;
        start_ref = wr_hit && par_req.wdata[7:0] == HSC_ACT_REF;
        start_set = wr_hit && par_req.wdata[7:0] == HSC_ACT_SET;
        idx_rise  = sw_sync_reg.index_pulse && !idx_prev_reg;
        sw_active = plan_reg.use_limit
                  ? (plan_reg.seek_neg ? sw_sync_reg.negative_end_switch
                                       : sw_sync_reg.positive_end_switch)
                  : sw_sync_reg.ref_switch;
        end_ahead = seek_dir_reg ? sw_sync_reg.negative_end_switch
                                 : sw_sync_reg.positive_end_switch;
        out_dir   = plan_reg.invert ? !seek_dir_reg : seek_dir_reg;
        fin_dir   = plan_reg.outside ? out_dir : !out_dir;
    end

    // Parameter registers; a method code above the legal range is not stored.
    always_ff @(posedge clk) begin
        if (rst) begin
            sp_limit_reg  <= HSC_RST_SP_LIMIT;
            sw_offset_reg <= HSC_RST_SW_OFFSET;
            home_pos_reg  <= HSC_RST_HOME_POS;
            ot_limit_reg  <= HSC_RST_OT_LIMIT;
            method_reg    <= HSC_RST_METHOD;
            action_reg    <= HSC_RST_ACTION;
        end else if (ce && par_req.wr) begin
            unique case (par_req.addr)
                HSC_ADDR_SP_LIMIT:    sp_limit_reg  <= par_req.wdata;
                HSC_ADDR_SW_OFFSET:   sw_offset_reg <= par_req.wdata;
                HSC_ADDR_HOME_POS:    home_pos_reg  <= par_req.wdata;
                HSC_ADDR_OT_LIMIT:    ot_limit_reg  <= par_req.wdata;
                HSC_ADDR_METHOD: begin
                    if (par_req.wdata[15:0] <= HSC_METHOD_MAX) begin
                        method_reg <= par_req.wdata[15:0];
                    end
                end
                HSC_ADDR_MODE_ACTION: action_reg <= par_req.wdata[7:0];
                default: ;
            endcase
        end
    end

    // Read data, registered; unmapped addresses read zero.
    always_ff @(posedge clk) begin
        if (rst) begin
            par_rdata <= '0;
        end else if (ce && par_req.rd) begin
            unique case (par_req.addr)
                HSC_ADDR_SP_LIMIT:    par_rdata <= sp_limit_reg;
                HSC_ADDR_SW_OFFSET:   par_rdata <= sw_offset_reg;
                HSC_ADDR_HOME_POS:    par_rdata <= home_pos_reg;
                HSC_ADDR_OT_LIMIT:    par_rdata <= ot_limit_reg;
                HSC_ADDR_METHOD:      par_rdata <= {16'h0000, method_reg};
                HSC_ADDR_MODE_ACTION: par_rdata <= {24'h000000, action_reg};
                HSC_ADDR_STATUS:      par_rdata <= {16'h0000, drive_status_word};
                default:              par_rdata <= '0;
            endcase
        end
    end

    // Settings are copied at start so edits during a movement wait for the next one.
    always_ff @(posedge clk) begin
        if (rst) begin
            sp_limit_act_reg  <= HSC_RST_SP_LIMIT;
            sw_offset_act_reg <= HSC_RST_SW_OFFSET;
            home_pos_act_reg  <= HSC_RST_HOME_POS;
            ot_limit_act_reg  <= HSC_RST_OT_LIMIT;
            plan_reg          <= '0;
        end else if (ce && (start_ref || start_set)) begin
            sp_limit_act_reg  <= sp_limit_reg;
            sw_offset_act_reg <= sw_offset_reg;
            home_pos_act_reg  <= home_pos_reg;
            ot_limit_act_reg  <= ot_limit_reg;
            plan_reg          <= plan_now;
        end
    end

    // Sequencer. Switch arrival turns the motor directly; the profile ramps the reversal.
    always_ff @(posedge clk) begin
        if (rst) begin
            state_reg      <= HSC_IDLE;
            motion         <= '0;
            reversed_reg   <= 1'b0;
            seek_dir_reg   <= 1'b0;
            mark_reg       <= '0;
            good_reg       <= 1'b0;
            err_reg        <= 1'b0;
            pos_load       <= 1'b0;
            pos_load_value <= '0;
        end else if (ce) begin
            pos_load <= 1'b0;
            unique case (state_reg)
                HSC_IDLE: begin
                    good_reg     <= 1'b0;
                    err_reg      <= 1'b0;
                    reversed_reg <= 1'b0;
                    seek_dir_reg <= plan_now.seek_neg;
                    if (start_set || (start_ref && plan_now.pos_set)) begin
                        // Position setting only works at standstill.
                        if (standstill) begin
                            pos_load       <= 1'b1;
                            pos_load_value <= home_pos_reg;
                            good_reg       <= 1'b1;
                        end else begin
                            err_reg <= 1'b1;
                        end
                        state_reg <= HSC_BRAKE;
                    end else if (start_ref && !plan_now.valid) begin
                        err_reg   <= 1'b1;
                        state_reg <= HSC_BRAKE;
                    end else if (start_ref && plan_now.index_only) begin
                        motion    <= '{run: 1'b1, dir_neg: plan_now.seek_neg, slow: 1'b1};
                        state_reg <= HSC_FINAL;
                    end else if (start_ref) begin
                        motion    <= '{run: 1'b1, dir_neg: plan_now.seek_neg, slow: 1'b0};
                        state_reg <= HSC_SEEK;
                    end
                end
                HSC_SEEK: begin
                    if (sw_active) begin
                        mark_reg  <= act_pos;
                        motion    <= '{run: 1'b1, dir_neg: out_dir, slow: 1'b1};
                        state_reg <= HSC_LEAVE;
                    end else if (!plan_reg.use_limit && end_ahead && !reversed_reg) begin
                        // Overtravel: turn round and start the return search.
                        reversed_reg <= 1'b1;
                        seek_dir_reg <= !seek_dir_reg;
                        mark_reg     <= act_pos;
                        motion       <= '{run: 1'b1, dir_neg: !seek_dir_reg, slow: 1'b0};
                    end else if (reversed_reg && ot_limit_act_reg != 32'h0000_0000
                                 && hsc_dist(act_pos, mark_reg) > ot_limit_act_reg) begin
                        err_reg   <= 1'b1;
                        motion    <= '0;
                        state_reg <= HSC_BRAKE;
                    end
                end
                HSC_LEAVE: begin
                    if (!sw_active) begin
                        mark_reg  <= act_pos; // Switching point.
                        motion    <= '{run: 1'b1, dir_neg: fin_dir, slow: 1'b1};
                        state_reg <= HSC_FINAL;
                    end else if (sp_limit_act_reg != 32'h0000_0000
                                 && hsc_dist(act_pos, mark_reg) > sp_limit_act_reg) begin
                        err_reg   <= 1'b1;
                        motion    <= '0;
                        state_reg <= HSC_BRAKE;
                    end
                end
                HSC_FINAL: begin
                    // Index methods never look at the offset distance.
                    if (plan_reg.end_index ? idx_rise
                        : hsc_dist(act_pos, mark_reg) >= sw_offset_act_reg) begin
                        pos_load       <= 1'b1;
                        pos_load_value <= home_pos_act_reg;
                        good_reg       <= 1'b1;
                        motion         <= '0;
                        state_reg      <= HSC_BRAKE;
                    end
                end
                HSC_BRAKE: begin
                    // End is reported only once the motor has stopped.
                    if (standstill) begin
                        state_reg <= HSC_IDLE;
                    end
                end
                default: state_reg <= HSC_IDLE; // Unused codes fall back to idle.
            endcase
            // Halt, quick stop and faults override any moving state.
            if (state_reg != HSC_IDLE && state_reg != HSC_BRAKE
                && (halt_req || quick_stop_req || fault_req)) begin
                motion    <= '0;
                good_reg  <= 1'b0;
                pos_load  <= 1'b0;
                // A cancelled load must not leave a new value behind without its pulse.
                pos_load_value <= pos_load_value;
                err_reg   <= fault_req;
                state_reg <= HSC_BRAKE;
            end
        end
    end

    // Status word and zero-point validity.
    always_ff @(posedge clk) begin
        if (rst) begin
            drive_status_word <= HSC_RST_STATUS;
            zero_valid        <= 1'b0;
        end else if (ce) begin
            if (state_reg == HSC_IDLE && (start_ref || start_set)) begin
                drive_status_word[HSC_STAT_END] <= 1'b0;
                drive_status_word[HSC_STAT_ERR] <= 1'b0;
                zero_valid                      <= 1'b0;
            end else if (state_reg == HSC_BRAKE && standstill) begin
                drive_status_word[HSC_STAT_END] <= 1'b1;
                drive_status_word[HSC_STAT_ERR] <= err_reg;
                zero_valid                      <= good_reg;
            end
        end
    end

endmodule // hsc_homing_sequence_control

// ### dv/hsc_motor_model.sv
// Behavioural motor with encoder, end switches, reference switch and index marks.
`timescale 1ns/1ns
module hsc_motor_model
    import hsc_pkg::*;
#(
    parameter int REF_LO  = 100,
    parameter int REF_HI  = 160,
    parameter int END_POS = 300
)(
    input  wire logic        clk,
    input  wire logic        rst,
    input  wire hsc_motion_t motion,
    input  wire logic        pos_load,
    input  wire logic [31:0] pos_load_value,
    output hsc_switch_t      switch_pins,
    output logic [31:0]      act_pos,
    output logic             standstill
);
    logic [2:0] idle_reg;
    int         p;

    // One unit per cycle while running; a load overrides the count like real position setting.
    always_ff @(posedge clk) begin
        if (rst) act_pos <= '0;
        else if (pos_load) act_pos <= pos_load_value;
        else if (motion.run) act_pos <= motion.dir_neg ? act_pos - 32'h1 : act_pos + 32'h1;
    end

    // The shaft coasts a few cycles after the command drops, so the sequencer must wait.
    always_ff @(posedge clk) begin
        if (rst || motion.run) idle_reg <= '0;
        else if (idle_reg != 3'h7) idle_reg <= idle_reg + 3'h1;
    end

    // Switch levels follow the position; the index mark repeats every 64 units.
    assign standstill = (idle_reg > 3'h3);
    assign p = $signed(act_pos);
    assign switch_pins.negative_end_switch = (p <= -END_POS);
    assign switch_pins.positive_end_switch = (p >= END_POS);
    assign switch_pins.ref_switch = (p >= REF_LO) && (p <= REF_HI);
    assign switch_pins.index_pulse = (p % 64) == 0;
endmodule // hsc_motor_model

// ### dv/hsc_checker.sv
// Port checker of the homing sequencer.
`timescale 1ns/1ns
module hsc_checker
    import hsc_pkg::*;
(
    input wire logic         clk,
    input wire logic         rst,
    input wire logic         ce,
    input wire hsc_par_req_t par_req,
    input wire logic [31:0]  par_rdata,
    input wire hsc_switch_t  switch_pins,
    input wire logic [31:0]  act_pos,
    input wire logic         standstill,
    input wire logic         halt_req,
    input wire logic         quick_stop_req,
    input wire logic         fault_req,
    input wire hsc_motion_t  motion,
    input wire logic         pos_load,
    input wire logic [31:0]  pos_load_value,
    input wire logic         zero_valid,
    input wire logic [15:0]  drive_status_word
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);
    logic ended;
    logic err;
    logic go;

    // A start counts only when written while the previous run has ended.
    assign ended = drive_status_word[HSC_STAT_END];
    assign err = drive_status_word[HSC_STAT_ERR];
    assign go = ce && par_req.wr && par_req.addr == HSC_ADDR_MODE_ACTION
        && par_req.wdata[7:0] == HSC_ACT_REF && ended;

    a_start_clears_end: assert property (go |=> !ended)
        else $error("End bit did not clear on start.");
    a_end_at_standstill: assert property ($rose(ended) |-> $past(standstill))
        else $error("Run ended without standstill.");
    a_error_with_end: assert property (err |-> ended)
        else $error("Error shown before the run ended.");
    a_ended_no_run: assert property (ended |-> !motion.run)
        else $error("Motion commanded after the end.");
    a_zero_on_success: assert property ($rose(zero_valid) |-> ended && !err)
        else $error("Zero point valid without clean end.");
    a_load_value_stands: assert property ($changed(pos_load_value) |-> pos_load)
        else $error("Load value moved without a load.");
    a_status_reserved: assert property (drive_status_word[13:0] == 14'h0)
        else $error("Reserved status bits set.");
    a_halt_stops_run: assert property ((halt_req || quick_stop_req) && ce && motion.run
        |-> ##[1:3] !motion.run) else $error("Halt did not stop the motion.");
    a_rdata_holds: assert property (!(ce && par_req.rd) |=> $stable(par_rdata))
        else $error("Read data changed without a read.");

    c_success: cover property ($rose(zero_valid));
    c_error_end: cover property ($rose(err));
    c_load: cover property (pos_load);
endmodule // hsc_checker

bind hsc_homing_sequence_control hsc_checker u_checker (
    .clk(clk), .rst(rst), .ce(ce), .par_req(par_req), .par_rdata(par_rdata),
    .switch_pins(switch_pins), .act_pos(act_pos), .standstill(standstill),
    .halt_req(halt_req), .quick_stop_req(quick_stop_req), .fault_req(fault_req),
    .motion(motion), .pos_load(pos_load), .pos_load_value(pos_load_value),
    .zero_valid(zero_valid), .drive_status_word(drive_status_word)
);

// ### dv/hsc_homing_sequence_control_tb_top.sv
// Self-checking bench of the homing sequencer driving a motor model.
`timescale 1ns/1ns
module hsc_homing_sequence_control_tb_top
    import hsc_pkg::*;
;
    logic         clk, rst, ce, pos_load, zero_valid, standstill;
    logic         halt_req, quick_stop_req, fault_req;
    hsc_par_req_t par_req;
    hsc_switch_t  switch_pins;
    hsc_motion_t  motion;
    logic [31:0]  par_rdata, act_pos, pos_load_value, load_at, d, h, o;
    logic [15:0]  drive_status_word;
    int           bad_count, n_compared, r;
    int           codes[22] = '{1, 2, 7, 8, 9, 10, 11, 12, 13, 14, 17, 18,
                                23, 24, 25, 26, 27, 28, 29, 30, 31, 34};
    logic [15:0]  addrs[5] = '{HSC_ADDR_SP_LIMIT, HSC_ADDR_SW_OFFSET, HSC_ADDR_HOME_POS,
                               HSC_ADDR_OT_LIMIT, HSC_ADDR_METHOD};
    logic [31:0]  rstv[5] = '{HSC_RST_SP_LIMIT, HSC_RST_SW_OFFSET, HSC_RST_HOME_POS,
                              HSC_RST_OT_LIMIT, 32'(HSC_RST_METHOD)};

    hsc_homing_sequence_control dut (.clk(clk), .rst(rst), .ce(ce), .par_req(par_req),
        .par_rdata(par_rdata), .switch_pins(switch_pins), .act_pos(act_pos),
        .standstill(standstill), .halt_req(halt_req), .quick_stop_req(quick_stop_req),
        .fault_req(fault_req), .motion(motion), .pos_load(pos_load),
        .pos_load_value(pos_load_value), .zero_valid(zero_valid),
        .drive_status_word(drive_status_word));
    hsc_motor_model u_motor (.clk(clk), .rst(rst), .motion(motion), .pos_load(pos_load),
        .pos_load_value(pos_load_value), .switch_pins(switch_pins), .act_pos(act_pos),
        .standstill(standstill));

    // 20 MHz clock.
    initial begin
        clk = 1'b0;
        forever #25 clk = ~clk;
    end

    // Position seen when the load pulse fires, before the model applies it.
    always @(posedge clk) if (pos_load) load_at <= act_pos;

    function automatic logic exp_neg(input int m);
        return m == 1 || m == 17 || m == 31 || (m >= 11 && m <= 14) || (m >= 27 && m <= 30);
    endfunction
    // Sync latency lets the shaft run a few units past the mark, hence the tolerance.
    function automatic logic near(input int a, input int b);
        return (a - b <= 6) && (b - a <= 6);
    endfunction

    task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string msg);
        n_compared++;
        if (got !== exp) begin
            bad_count++;
            $display("[FAIL] %0t %s got %h expected %h", $time, msg, got, exp);
        end
    endtask
    task automatic wr(input logic [15:0] a, input logic [31:0] v);
        @(posedge clk);
        par_req <= '{addr: a, wdata: v, wr: 1'b1, rd: 1'b0};
        @(posedge clk);
        par_req.wr <= 1'b0;
    endtask
    task automatic rd(input logic [15:0] a, output logic [31:0] v);
        @(posedge clk);
        par_req <= '{addr: a, wdata: 32'h0, wr: 1'b0, rd: 1'b1};
        @(posedge clk);
        par_req.rd <= 1'b0;
        #1 v = par_rdata;
    endtask
    task automatic start(input int m, input logic [7:0] act);
        wr(HSC_ADDR_METHOD, 32'(m));
        wr(HSC_ADDR_MODE_ACTION, {24'h0, act});
        #1;
        if (act == HSC_ACT_REF) chk({30'h0, motion.run, motion.dir_neg}, {30'h1, exp_neg(m)},
            "start direction");
    endtask
    // Clock enable may stutter while waiting, to show that frozen cycles change nothing.
    task automatic wait_end(input logic jit);
        int n;
        n = 0;
        do begin
            @(posedge clk);
            ce <= jit ? ($urandom_range(0, 7) != 0) : 1'b1;
            #1 n++;
        end while (drive_status_word[HSC_STAT_END] !== 1'b1 && n < 4000);
        @(posedge clk);
        ce <= 1'b1;
        chk(32'(n < 4000), 32'h1, "run never ended");
    endtask
    task automatic place(input logic [31:0] v);
        wr(HSC_ADDR_HOME_POS, v);
        start(35, HSC_ACT_SET);
        wait_end(1'b0);
    endtask
    task automatic final_report();
        $display("Comparisons %0d, mismatches %0d", n_compared, bad_count);
        if (bad_count == 0 && n_compared > 0) $display("Run complete: PASS");
        else $display("Run complete: FAIL");
        $finish;
    endtask

    // Watchdog at 40,000 cycles, well beyond the expected run of some 7,000.
    initial begin
        #2000000;
        bad_count++;
        $display("[FAIL] %0t watchdog expired", $time);
        final_report();
    end

    initial begin
        void'($urandom(32'h9f9b));
        {rst, ce, halt_req, quick_stop_req, fault_req} = 5'b11000;
        par_req = '0;
        repeat (16) @(posedge clk);
        rst <= 1'b0;
        #1 chk({16'h0, drive_status_word}, 32'h4000, "status after reset");
        for (int i = 0; i < 5; i++) begin
            rd(addrs[i], d);
            chk(d, rstv[i], "reset value");
            h = (i == 4) ? 32'($urandom_range(0, 35)) : $urandom;
            wr(addrs[i], h);
            rd(addrs[i], d);
            chk(d, h, "write readback");
        end
        wr(HSC_ADDR_METHOD, 32'($urandom_range(36, 200)));
        rd(HSC_ADDR_METHOD, d);
        chk(d, h, "method above range kept out");
        wr(HSC_ADDR_SP_LIMIT, 32'h0);
        wr(HSC_ADDR_OT_LIMIT, 32'h0);
        foreach (codes[i]) begin
            place(exp_neg(codes[i]) ? 32'd250 : 32'd0);
            o = 32'($urandom_range(20, 40));
            wr(HSC_ADDR_SW_OFFSET, o);
            h = 32'($urandom_range(0, 80)) - 32'd40;
            wr(HSC_ADDR_HOME_POS, h);
            start(codes[i], HSC_ACT_REF);
            wait_end(1'b0);
            chk({drive_status_word[HSC_STAT_ERR], zero_valid, pos_load_value[29:0]},
                {2'b01, h[29:0]}, "homing result");
            r = $signed(load_at) % 64;
            if (codes[i] <= 14 || codes[i] >= 31) chk(32'(near(r, 0) || near(r, 64)
                || near(r, -64)), 32'h1, "index end point");
            if (codes[i] == 17) chk(32'(near($signed(load_at), $signed(o) - 299)), 32'h1,
                "distance end point");
        end
        place(32'd0);
        wr(HSC_ADDR_SP_LIMIT, 32'd5);
        start(25, HSC_ACT_REF);
        wait_end(1'b0);
        chk({30'h0, drive_status_word[HSC_STAT_ERR], zero_valid}, 32'h2, "limit cancel");
        wr(HSC_ADDR_SP_LIMIT, 32'h0);
        // Negative search from below the reference switch overtravels the end switch.
        for (int k = 0; k < 2; k++) begin
            place(32'd50);
            wr(HSC_ADDR_OT_LIMIT, k ? 32'd1000 : 32'd50);
            start(27, HSC_ACT_REF);
            wait_end(1'b0);
            chk({30'h0, drive_status_word[HSC_STAT_ERR], zero_valid}, k ? 32'h1 : 32'h2,
                "overtravel search");
        end
        wr(HSC_ADDR_OT_LIMIT, 32'h0);
        // Code 0 is storable but names no procedure, so the run ends with an error.
        wr(HSC_ADDR_METHOD, 32'h0);
        wr(HSC_ADDR_MODE_ACTION, 32'(HSC_ACT_REF));
        wait_end(1'b0);
        chk({30'h0, drive_status_word[HSC_STAT_ERR], zero_valid}, 32'h2, "unused code");
        for (int k = 0; k < 4; k++) begin
            place(32'd1);
            h = $urandom;
            wr(HSC_ADDR_HOME_POS, h);
            start(34, HSC_ACT_REF);
            wr(HSC_ADDR_HOME_POS, ~h);
            repeat (5) @(posedge clk);
            halt_req <= (k == 1);
            fault_req <= (k == 2);
            quick_stop_req <= (k == 3);
            wait_end(1'b1);
            {halt_req, fault_req, quick_stop_req} <= 3'b000;
            chk({30'h0, drive_status_word[HSC_STAT_ERR], zero_valid},
                {30'h0, k == 2, k == 0}, "stop outcome");
            if (k == 0) chk(pos_load_value, h, "late setting change");
        end
        final_report();
    end
endmodule // hsc_homing_sequence_control_tb_top
